// >>> test/smr_rx_chk.sv
// Checker: port assertions for the synchronous master receiver
`timescale 1ns/100ps
module smr_rx_chk (
  input wire logic        clk,        // Clock
  input wire logic        rst,        // Reset
  input wire logic        hsel,       // Select
  input wire logic [31:0] haddr,      // Address
  input wire logic [1:0]  htrans,     // Type
  input wire logic        hwrite,     // Write
  input wire logic [2:0]  hsize,      // Size
  input wire logic [31:0] hwdata,     // Wdata
  input wire logic        hready,     // Ready in
  input wire logic [31:0] hrdata,     // Rdata
  input wire logic        hreadyout,  // Ready out
  input wire logic        hresp,      // Response
  input wire logic        rx_data_in, // Data pin
  input wire logic        sclk_out,   // Shift clock
  input wire logic        sclk_oe,    // Clock enable
  input wire logic        irq         // Interrupt
);
  logic rd_ff;
  logic wr_ff;
  //////////////////////////////////////////////////////////////////////////////
  // Data phase trackers, one cycle behind the taken address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      rd_ff <= hsel && hready && htrans == smr_pkg::HTRANS_NONSEQ && !hwrite;
      wr_ff <= hsel && hready && htrans == smr_pkg::HTRANS_NONSEQ && hwrite;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // Half periods assume a divisor of at least one
  chk_ready_high: assert property (hreadyout) else $error("slave stalled");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_read_idle: assert property (!rd_ff |-> hrdata == smr_pkg::ZERO32)
    else $error("read data outside data phase");
  chk_clk_with_oe: assert property (sclk_out |-> sclk_oe)
    else $error("clock high while not driven");
  chk_high_half: assert property ($rose(sclk_out) |=> sclk_out)
    else $error("high half too short");
  chk_low_half: assert property ($fell(sclk_out) && sclk_oe |=> !sclk_out)
    else $error("low half too short");
  chk_oe_by_write: assert property ($changed(sclk_oe) |-> $past(wr_ff) || $past(wr_ff, 2))
    else $error("clock enable moved without a write");
  chk_irq_drop: assert property ($fell(irq) |-> $past(wr_ff))
    else $error("interrupt dropped without a write");
  cov_clk: cover property ($rose(sclk_out));
  cov_irq: cover property ($rose(irq));
  cov_off: cover property ($fell(irq));
endmodule : smr_rx_chk
bind smr_rx smr_rx_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_data_in(rx_data_in),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .irq(irq));

// >>> test/smr_rx_tb.sv
// Testbench for the synchronous master receiver
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module smr_rx_tb;
  logic        clk, rst, hsel, hwrite, rx, sclk, oe, irq, rdy, resp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  word;
  logic [3:0]  nbits;
  logic [7:0]  falls;
  int          checked, miscompares, cyc;
  smr_rx DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
    .hreadyout(rdy), .hresp(resp), .rx_data_in(rx), .sclk_out(sclk), .sclk_oe(oe), .irq(irq));
  smr_slave_model PEER (.clk(clk), .rst(rst), .sclk(sclk), .oe(oe), .word(word),
    .nbits(nbits), .sdata(rx), .falls(falls));
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  // One single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= smr_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, smr_pkg::ZERO32);
    `CHK(n, e, q)
  endtask : rd
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // Hang guard, far above the 96 to 108 cycles per narrow word
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk    = 1'b0;
    rst    = 1'b1;
    hsel   = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize  = 3'h2;
    {haddr, hwdata, word, nbits} = {64'h0, 9'h0A5, 4'h8};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b1, 8'h1C, 32'h000000FF);
    rd(smr_pkg::OFS_CTRL, 32'h0, "ctrl rst");
    rd(smr_pkg::OFS_CFG, 32'h0, "cfg rst");
    rd(8'h1C, 32'h0, "unmapped");
    $display("test reset done");
    // divisor, master mode, unmask, port on
    xfer(1'b1, smr_pkg::OFS_BAUDL, 32'h00000005);
    xfer(1'b1, smr_pkg::OFS_BAUDH, 32'h00000001); // unused while narrow
    xfer(1'b1, smr_pkg::OFS_CFG, 32'h00000003);
    xfer(1'b1, smr_pkg::OFS_MASK, 32'h00000001);
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h00000080);
    repeat (40) @(posedge clk);
    `CHK("idle falls", 8'h00, falls)
    `CHK("oe on", 1'b1, oe)
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000A0);
    repeat (2000) if (irq !== 1'b1) @(posedge clk);
    repeat (60) @(posedge clk);
    `CHK("irq single", 1'b1, irq)
    `CHK("falls single", 8'h08, falls)
    rd(smr_pkg::OFS_DATA, 32'hA5, "data single");
    rd(smr_pkg::OFS_CTRL, 32'h80, "ctrl single");
    rd(smr_pkg::OFS_STAT, 32'h1, "stat single");
    xfer(1'b1, smr_pkg::OFS_STAT, 32'h00000001);
    @(negedge clk);
    `CHK("irq clear", 1'b0, irq)
    $display("test single done");
    // ninth bit armed before the enable
    word  <= 9'h13C;
    nbits <= 4'h9;
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000C0);
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000E0);
    repeat (2000) if (irq !== 1'b1) @(posedge clk);
    `CHK("falls ninth", 8'h11, falls)
    rd(smr_pkg::OFS_CTRL, 32'hC1, "ctrl ninth");
    rd(smr_pkg::OFS_DATA, 32'h3C, "data ninth");
    xfer(1'b1, smr_pkg::OFS_STAT, 32'h00000001);
    $display("test ninth done");
    // Both enables, masked, second word unread
    word <= 9'h15A;
    xfer(1'b1, smr_pkg::OFS_MASK, 32'h00000000);
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000F0);
    repeat (2000) if (falls !== 8'h24) @(posedge clk);
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000C0);
    `CHK("falls cont", 8'h24, falls)
    rd(smr_pkg::OFS_CTRL, 32'hC1, "ctrl stop");
    rd(smr_pkg::OFS_STAT, 32'h3, "stat cont");
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, smr_pkg::OFS_MASK, 32'h00000003);
    @(negedge clk);
    `CHK("irq unmask", 1'b1, irq)
    xfer(1'b1, smr_pkg::OFS_STAT, 32'h00000003);
    @(negedge clk);
    `CHK("irq w1c", 1'b0, irq)
    rd(smr_pkg::OFS_DATA, 32'h5A, "data cont");
    $display("test continuous done");
    // Wide divisor 0x105: 262-clock halves, so one fall in 400 clocks
    xfer(1'b1, smr_pkg::OFS_CFG, 32'h00000007);
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h000000A0);
    repeat (400) @(posedge clk);
    `CHK("falls wide", 8'h25, falls)
    xfer(1'b1, smr_pkg::OFS_CTRL, 32'h00000080);
    repeat (600) @(posedge clk);
    `CHK("falls abort", 8'h25, falls)
    `CHK("clk idle", 1'b0, sclk)
    $display("test wide done");
    final_report();
  end
endmodule : smr_rx_tb

// >>> test/smr_slave_model.sv
// Model of the external slave feeding serial words to the receiver
`timescale 1ns/100ps
module smr_slave_model (
  input  wire logic       clk,    // System clock
  input  wire logic       rst,    // Reset
  input  wire logic       sclk,   // Shift clock
  input  wire logic       oe,     // Clock driven
  input  wire logic [8:0] word,   // Word, LSB first
  input  wire logic [3:0] nbits,  // Bits per word
  output logic            sdata,  // Serial data
  output logic [7:0]      falls   // Falls seen
);
  logic       sclk_q;
  logic [3:0] idx;
  // next bit after fall
  // Moving just after the fall keeps data stable a whole period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      idx    <= 4'h0;
      falls  <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) begin
        idx   <= (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
        falls <= falls + 8'h01;
      end
    end
  end
  // Undriven clock: show the inverse, never a lucky level
  assign sdata = oe ? word[idx] : ~word[idx];
endmodule : smr_slave_model

// >>> verilog/smr_pkg.sv
// Package: register map, fields and timing for the synchronous master receiver
package smr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // receive_status_control_reg
  localparam logic [7:0] OFS_DATA   = 8'h04;  // receive_data_reg
  localparam logic [7:0] OFS_BAUDL  = 8'h08;  // baud_divisor_low
  localparam logic [7:0] OFS_BAUDH  = 8'h0C;  // baud_divisor_high
  localparam logic [7:0] OFS_CFG    = 8'h10;  // mode configuration
  localparam logic [7:0] OFS_STAT   = 8'h14;  // sticky interrupt status
  localparam logic [7:0] OFS_MASK   = 8'h18;  // interrupt mask
  // Control register fields
  localparam int B_RX9D  = 0;   // received ninth bit
  localparam int B_OERR  = 1;   // overrun error
  localparam int B_FERR  = 2;   // framing error, always zero in this mode
  localparam int B_RX9EN = 6;   // ninth_bit_receive_enable
  localparam int B_SERIAL_PORT_ENABLE  = 7;   // serial_port_enable
  localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4;   // continuous_receive_enable
  localparam int B_SINGLE_RECEIVE_ENABLE  = 5;   // single_receive_enable
  // Config register fields
  localparam int B_SYNC  = 0;   // clocked mode select
  localparam int B_CLOCK_SOURCE_MASTER_SELECT  = 1;   // clock_source_master_select
  localparam int B_WIDE_BAUD_GENERATOR_SELECT = 2;   // wide_baud_generator_select
  localparam int B_CKP   = 3;   // clock_polarity_select
  // Status / mask fields
  localparam int B_IDONE = 0;   // receive_done_flag
  localparam int B_IOERR = 1;   // overrun event
  localparam int NIRQ    = 2;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [3:0]  CFG_RST  = 4'h0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO32   = 32'h00000000;

  typedef enum logic [1:0] {SMR_IDLE, SMR_LOW, SMR_HIGH} smr_state_e;

  // Captured AHB address phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } smr_aphase_s;
endpackage : smr_pkg

// >>> verilog/smr_rx.sv
// Synchronous master serial receiver with AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Reception starts only when single or continuous receive enable is set
// - Data pin is sampled on each falling edge of the shift clock
// - Single enable alone receives one word, then clears and stops
// - Continuous enable receives words back to back until cleared
// - With both enables set, continuous reception wins
// - Each finished word sets the done flag; enabled flag raises interrupt
// - Ninth bit and error flags appear in the status/control register
// - Lower eight bits of each word are read from the data register
// - Clearing continuous enable clears pending reception error
module smr_rx (
  input  wire logic        clk,         // System clock, 100 MHz
  input  wire logic        rst,         // Async reset, active high
  input  wire logic        hsel,        // AHB slave select
  input  wire logic [31:0] haddr,       // AHB address
  input  wire logic [1:0]  htrans,      // AHB transfer type
  input  wire logic        hwrite,      // AHB write
  input  wire logic [2:0]  hsize,       // AHB size, word only
  input  wire logic [31:0] hwdata,      // AHB write data
  input  wire logic        hready,      // AHB bus ready
  output logic      [31:0] hrdata,      // AHB read data
  output logic             hreadyout,   // AHB slave ready
  output logic             hresp,       // AHB response, always OKAY
  input  wire logic        rx_data_in,  // serial_data_pin input
  output logic             sclk_out,    // Shift clock pin output
  output logic             sclk_oe,     // Shift clock drive enable
  output logic             irq          // Level interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // The block is link master: it drives the shift clock and takes one bit
  // per falling edge. Bus writes land at the end of their data phase, so a
  // read issued right after a write already sees the new value. Status
  // bits are sticky; the mask only gates the level output.
  // Registers and internal nets
  logic [7:0]               ctrl_ff;
  logic [3:0]               cfg_ff;
  logic [15:0]              baud_ff;
  logic [7:0]               data_ff;
  logic [smr_pkg::NIRQ-1:0] stat_ff;
  logic [smr_pkg::NIRQ-1:0] mask_ff;
  logic                     ninth_ff;
  logic                     oerr_ff;
  logic                     unread_ff;
  smr_pkg::smr_aphase_s     ap_ff;
  smr_pkg::smr_state_e      state_ff;
  logic [15:0]              cnt_ff;
  logic [3:0]               bit_ff;
  logic [8:0]               shift_ff;
  logic                     sclk_ff;
  logic                     rx_s1_ff;
  logic                     rx_s2_ff;
  logic                     word_done;
  logic                     srend_clr;
  logic                     tick;
  logic [15:0]              nxt_cnt;
  logic [3:0]               last_bit;
  logic                     active;
  logic                     wr_en;
  logic                     rd_data;
  logic [31:0]              wval;
  logic [smr_pkg::NIRQ-1:0] stat_set;
  logic                     stat_clr;
  logic                     overrun;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, so ready and response are constant
  // Size is ignored; every register is one aligned word
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wval      = hwdata;
  assign wr_en     = ap_ff.wr;
  assign rd_data   = ap_ff.rd && (ap_ff.addr == smr_pkg::OFS_DATA);

  // Address phase capture
  // Taken only while hready is high, so a stalled bus starts no phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ap_ff <= '0;
    end else if (hready) begin
      ap_ff.wr   <= hsel && (htrans == smr_pkg::HTRANS_NONSEQ) && hwrite;
      ap_ff.rd   <= hsel && (htrans == smr_pkg::HTRANS_NONSEQ) && !hwrite;
      ap_ff.addr <= {haddr[7:2], 2'h0};
    end else begin
      ap_ff.wr <= 1'b0;
      ap_ff.rd <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  // A data read also retires the unread word for overrun tracking
  always_comb begin
    hrdata = smr_pkg::ZERO32;
    if (ap_ff.rd) begin
      unique case (ap_ff.addr)
        smr_pkg::OFS_CTRL: begin
          hrdata[7:0] = {ctrl_ff[7:3], 1'b0, oerr_ff, ninth_ff};
        end
        smr_pkg::OFS_DATA:  hrdata[7:0]  = data_ff;
        smr_pkg::OFS_BAUDL: hrdata[7:0]  = baud_ff[7:0];
        smr_pkg::OFS_BAUDH: hrdata[7:0]  = baud_ff[15:8];
        smr_pkg::OFS_CFG:   hrdata[3:0]  = cfg_ff;
        smr_pkg::OFS_STAT:  hrdata[1:0]  = stat_ff;
        smr_pkg::OFS_MASK:  hrdata[1:0]  = mask_ff;
        default:            hrdata       = smr_pkg::ZERO32;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register; a software write wins over the hardware clear
  // of the single enable, since the write carries the newer intent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= smr_pkg::CTRL_RST;
    end else if (wr_en && ap_ff.addr == smr_pkg::OFS_CTRL) begin
      ctrl_ff <= {wval[7:3], 3'h0};
    end else if (srend_clr) begin
      ctrl_ff[smr_pkg::B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
    end
  end

  // Configuration and baud divisors
  // Divisors are used live; change them only while the link is idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff  <= smr_pkg::CFG_RST;
      baud_ff <= smr_pkg::BAUD_RST;
      mask_ff <= '0;
    end else if (wr_en) begin
      if (ap_ff.addr == smr_pkg::OFS_CFG)   cfg_ff        <= wval[3:0];
      if (ap_ff.addr == smr_pkg::OFS_BAUDL) baud_ff[7:0]  <= wval[7:0];
      if (ap_ff.addr == smr_pkg::OFS_BAUDH) baud_ff[15:8] <= wval[7:0];
      if (ap_ff.addr == smr_pkg::OFS_MASK)  mask_ff       <= wval[1:0];
    end
  end

  // Overrun: a word lands while the previous one is still unread;
  // a data read in the same cycle counts as taken in time
  assign overrun = word_done && unread_ff && !rd_data;

  // Received data, ninth bit and overrun; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_ff   <= '0;
      ninth_ff  <= 1'b0;
      oerr_ff   <= 1'b0;
      unread_ff <= 1'b0;
    end else begin
      if (word_done) begin
        // Nine-bit words sit at the bottom, eight-bit words one place up
        // word to data register
        data_ff   <= ctrl_ff[smr_pkg::B_RX9EN] ? shift_ff[7:0] : shift_ff[8:1];
        ninth_ff  <= ctrl_ff[smr_pkg::B_RX9EN] ? shift_ff[8] : 1'b0;
        unread_ff <= 1'b1;
      end else if (rd_data) begin
        unread_ff <= 1'b0;
      end
      if (overrun) begin
        oerr_ff <= 1'b1;
      end else if (!ctrl_ff[smr_pkg::B_CONTINUOUS_RECEIVE_ENABLE]) begin
        oerr_ff <= 1'b0;
      end
    end
  end

  // Write-one-to-clear strobe and event sources of the status bits
  assign stat_clr = wr_en && (ap_ff.addr == smr_pkg::OFS_STAT);
  assign stat_set[smr_pkg::B_IDONE] = word_done;
  assign stat_set[smr_pkg::B_IOERR] = overrun;

  // Sticky status per bit; a new event wins over a same-cycle clear
  generate
    for (genvar gi = 0; gi < smr_pkg::NIRQ; gi++) begin : g_stat
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stat_ff[gi] <= 1'b0;
        end else if (stat_set[gi]) begin
          stat_ff[gi] <= 1'b1;
        end else if (stat_clr && wval[gi]) begin
          stat_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // masked interrupt level
  // Software clears the source bit, never the line itself
  assign irq = |(stat_ff & mask_ff);

  //////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser
  // Only the second flop feeds logic; the first may be metastable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1_ff <= 1'b0;
      rx_s2_ff <= 1'b0;
    end else begin
      rx_s1_ff <= rx_data_in;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // enables gate reception; master, enabled, synchronous only
  // Port enable, clocked mode and master clock must all be set as well
  assign active = ctrl_ff[smr_pkg::B_SERIAL_PORT_ENABLE] && cfg_ff[smr_pkg::B_SYNC] &&
                  cfg_ff[smr_pkg::B_CLOCK_SOURCE_MASTER_SELECT] &&
                  (ctrl_ff[smr_pkg::B_SINGLE_RECEIVE_ENABLE] || ctrl_ff[smr_pkg::B_CONTINUOUS_RECEIVE_ENABLE]);
  assign last_bit = ctrl_ff[smr_pkg::B_RX9EN] ? 4'h8 : 4'h7;
  // Baud tick: divisor+1 cycles per half period; 8-bit divisor when narrow
  // Narrow mode ignores the high divisor byte entirely
  assign nxt_cnt  = cfg_ff[smr_pkg::B_WIDE_BAUD_GENERATOR_SELECT] ? baud_ff : {8'h00, baud_ff[7:0]};
  assign tick     = (cnt_ff == 16'h0000);

  //////////////////////////////////////////////////////////////////////////////
  // Link side: baud timing, bit sequencing and pin drive

  // shift clock generator and bit sequencer
  // Each half period lasts divisor plus one clocks. Dropping every set
  // receive enable aborts at once and discards the partial word; the shift
  // clock returns to its idle level one clock later. The far side
  // should move its data just after a fall, which leaves it a full
  // period to settle through the two-flop synchroniser.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= smr_pkg::SMR_IDLE;
      cnt_ff   <= '0;
      bit_ff   <= '0;
      shift_ff <= '0;
      sclk_ff  <= 1'b0;
    end else begin
      unique case (state_ff)
        smr_pkg::SMR_IDLE: begin
          // Preload the divisor so the first high half is full length
          sclk_ff <= 1'b0;
          bit_ff  <= '0;
          cnt_ff  <= nxt_cnt;
          if (active) begin
            state_ff <= smr_pkg::SMR_HIGH;
            sclk_ff  <= 1'b1;
          end
        end
        smr_pkg::SMR_HIGH: begin
          cnt_ff <= tick ? nxt_cnt : cnt_ff - 16'h0001;
          if (!active) begin
            state_ff <= smr_pkg::SMR_IDLE;
          end else if (tick) begin
            sclk_ff  <= 1'b0;
            shift_ff <= {rx_s2_ff, shift_ff[8:1]};
            state_ff <= smr_pkg::SMR_LOW;
          end
        end
        smr_pkg::SMR_LOW: begin
          cnt_ff <= tick ? nxt_cnt : cnt_ff - 16'h0001;
          if (!active) begin
            state_ff <= smr_pkg::SMR_IDLE;
          end else if (tick) begin
            bit_ff <= (bit_ff == last_bit) ? 4'h0 : bit_ff + 4'h1;
            // continuous keeps going; single ends after one word
            if (bit_ff == last_bit && !ctrl_ff[smr_pkg::B_CONTINUOUS_RECEIVE_ENABLE]) begin
              state_ff <= smr_pkg::SMR_IDLE;
            end else begin
              sclk_ff  <= 1'b1;
              state_ff <= smr_pkg::SMR_HIGH;
            end
          end
        end
      endcase
    end
  end

  // Word completes at end of the last low half period
  // Single mode clears its enable on the same edge the word lands
  assign word_done = (state_ff == smr_pkg::SMR_LOW) && tick && active &&
                     (bit_ff == last_bit);
  assign srend_clr = word_done && !ctrl_ff[smr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];

  // Shift clock pin; polarity select inverts the idle level
  // The pin stays driven between words while the port is set up as
  // master, so the far side never sees a floating clock
  assign sclk_out = sclk_ff ^ cfg_ff[smr_pkg::B_CKP];
  assign sclk_oe  = ctrl_ff[smr_pkg::B_SERIAL_PORT_ENABLE] && cfg_ff[smr_pkg::B_SYNC] &&
                    cfg_ff[smr_pkg::B_CLOCK_SOURCE_MASTER_SELECT];

endmodule : smr_rx
